// ### hw/tpic_timer_capture.sv
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tpic_map.svh"
// Functional notes
// - Wide-mode bit in lower control chains both timers into one 32-bit timer.
// - In wide mode upper run, gate, prescale and source bits are ignored.
// - Run bit starts counting when set and stops it when clear.
// - Halt-in-idle bit stops a timer while the device is idle.
// - Gating counts only while gate is high; ignored with external clock.
// - Divide field selects 1:1, 1:8, 1:64 or 1:256 prescale.
// - Source bit selects external rising edges or the internal clock.
// - Wide pair runs in idle only when lower halt-in-idle is clear.
// - Lower count is low word, upper count high word; period likewise.
// - Wide pair uses lower clock and gate; match sets upper flag.
// - A qualifying pin event latches the chosen timer's 16-bit count.
// - Base select 1 captures lower timer, 0 captures upper timer.
// - Mode field picks off, any edge, fall, rise, 4th or 16th rise.
// - Mode 111 is only a rising-edge wake interrupt during sleep or idle.
// - Captures-per-interrupt field fires after 1, 2, 3 or 4 captures.
// - In any-edge mode the per-interrupt count is not used.
// - Each channel buffers captures in a four-word FIFO.
// - Read-only overflow flag sets when a capture overflows the buffer.
// - Buffer-not-empty bit is high while unread captures remain.
// - Capture halt-in-idle stops captures, but not the mode 111 wake, while the CPU idles.
// - A capture pin can wake the device from sleep and idle.
// - Up to eight channels, each with its own time-base choice.
module tpic_timer_capture
	import tpic_pkg::*;
#(
	parameter int NCH = 8
) (
	// System.
	input wire logic clock,
	input wire logic resetn,
	// Classic Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Device power state and pins.
	input wire logic cpuIdle,
	input wire logic cpuSleep,
	input wire logic lowerGate,
	input wire logic upperGate,
	input wire logic lowerExtCountPin,
	input wire logic upperExtCountPin,
	input wire logic [NCH-1:0] captureInputPin,
	// Events.
	output logic lowerMatchFlag,
	output logic upperMatchFlag,
	output logic [NCH-1:0] captureIrq,
	output logic wakeRequest
);
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [15:0] lowerCtl_reg, upperCtl_reg;
	logic [15:0] lowerCount_reg, upperCount_reg;
	logic [15:0] lowerPeriod_reg, upperPeriod_reg;
	logic lowerFlag_reg, upperFlag_reg;
	logic [7:0] lowerDiv_reg, upperDiv_reg;
	logic lowerExtPrev_reg, upperExtPrev_reg;
	tpic_bstate_t busState_reg;
	logic [31:0] rdata_reg;
	logic wakeReq_reg;
	logic [15:0] capCtl_reg [NCH];
	logic [15:0] fifo_reg [NCH][`TPIC_FIFO_DEPTH];
	logic [2:0] fill_reg [NCH];
	logic [1:0] rdPtr_reg [NCH];
	logic [1:0] wrPtr_reg [NCH];
	logic [NCH-1:0] ovf_reg;
	logic [NCH-1:0] pinPrev_reg;
	logic [3:0] preCnt_reg [NCH];
	logic [1:0] irqCnt_reg [NCH];
	logic [NCH-1:0] capIrq_reg;
	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	logic busReq, wrAcc, rdAcc;
	assign busReq = wb_cyc_i && wb_stb_i && busState_reg == TPIC_BS_IDLE;
	assign wrAcc = busReq && wb_we_i;
	assign rdAcc = busReq && !wb_we_i;
	// Byte-lane merge of a 16-bit register; only lanes 0 and 1 matter.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] mask);
		return {wb_sel_i[1] ? wb_dat_i[15:8] : old[15:8],
			wb_sel_i[0] ? wb_dat_i[7:0] : old[7:0]} & mask;
	endfunction

	// ------------------------------------------------------------------
	// Timer pair
	// ------------------------------------------------------------------
	logic wide;
	logic [15:0] effUpperCtl;
	assign wide = lowerCtl_reg[`TPIC_B_WIDE];
	// The upper control is replaced wholesale in wide mode.
	assign effUpperCtl = wide ? lowerCtl_reg : upperCtl_reg;

	// Prescale terminal count for a divide field.
	function automatic logic [7:0] divLim(input logic [1:0] sel);
		case (sel)
			2'h0: return 8'h00;
			2'h1: return `TPIC_DIV8;
			2'h2: return `TPIC_DIV64;
			default: return `TPIC_DIV256;
		endcase
	endfunction
	logic lowerExtEdge, upperExtEdge, lowerBase, upperBase;
	logic [7:0] lowerLim, upperLim;
	logic lowerTick, upperTick;
	assign lowerExtEdge = lowerExtCountPin && !lowerExtPrev_reg;
	assign upperExtEdge = upperExtCountPin && !upperExtPrev_reg;
	// External edges ignore the gate bit; the internal clock honours it.
	// The prescaler advances on each source event, even mid-divide.
	assign lowerBase = lowerCtl_reg[`TPIC_B_RUN]
		&& !(lowerCtl_reg[`TPIC_B_SIDL] && cpuIdle)
		&& (lowerCtl_reg[`TPIC_B_CSRC] ? lowerExtEdge
		: (!lowerCtl_reg[`TPIC_B_GATE] || lowerGate));
	assign upperBase = effUpperCtl[`TPIC_B_RUN]
		&& !(effUpperCtl[`TPIC_B_SIDL] && cpuIdle)
		&& (effUpperCtl[`TPIC_B_CSRC] ? upperExtEdge
		: (!effUpperCtl[`TPIC_B_GATE] || upperGate));
	assign lowerLim = divLim(lowerCtl_reg[`TPIC_B_DIVHI:`TPIC_B_DIVLO]);
	assign upperLim = divLim(effUpperCtl[`TPIC_B_DIVHI:`TPIC_B_DIVLO]);
	// A count above a newly chosen smaller limit ends the divide at once,
	// so a prescale change never stalls for a full wrap.
	assign lowerTick = lowerBase && lowerDiv_reg >= lowerLim;
	assign upperTick = upperBase && upperDiv_reg >= upperLim;
	// Prescalers and count-pin edge history; upper prescaler idles if wide.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			lowerExtPrev_reg <= 1'b0;
			upperExtPrev_reg <= 1'b0;
			lowerDiv_reg <= 8'h00;
			upperDiv_reg <= 8'h00;
		end else begin
			lowerExtPrev_reg <= lowerExtCountPin;
			upperExtPrev_reg <= upperExtCountPin;
			if (lowerTick) begin
				lowerDiv_reg <= 8'h00;
			end else if (lowerBase) begin
				lowerDiv_reg <= lowerDiv_reg + 8'h01;
			end
			if (wide || upperTick) begin
				upperDiv_reg <= 8'h00;
			end else if (upperBase) begin
				upperDiv_reg <= upperDiv_reg + 8'h01;
			end
		end
	end

	logic wideMatch, lowerMatch, upperMatch;
	assign wideMatch = {upperCount_reg, lowerCount_reg}
		== {upperPeriod_reg, lowerPeriod_reg};
	assign lowerMatch = lowerCount_reg == lowerPeriod_reg;
	assign upperMatch = upperCount_reg == upperPeriod_reg;

	// Counters; a bus write to a count wins over counting.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			lowerCount_reg <= 16'h0000;
			upperCount_reg <= 16'h0000;
		end else begin
			if (wrAcc && wb_adr_i == `TPIC_OFS_LCNT) begin
				lowerCount_reg <= merge16(lowerCount_reg, 16'hFFFF);
			end else if (lowerTick) begin
				lowerCount_reg <= (wide ? wideMatch : lowerMatch) ? 16'h0000
					: lowerCount_reg + 16'h0001;
			end
			if (wrAcc && wb_adr_i == `TPIC_OFS_UCNT) begin
				upperCount_reg <= merge16(upperCount_reg, 16'hFFFF);
			end else if (wide && lowerTick) begin
				// Lower clock drives the pair; carry from the low word.
				if (wideMatch) begin
					upperCount_reg <= 16'h0000;
				end else if (lowerCount_reg == 16'hFFFF) begin
					upperCount_reg <= upperCount_reg + 16'h0001;
				end
			end else if (!wide && upperTick) begin
				upperCount_reg <= upperMatch ? 16'h0000
					: upperCount_reg + 16'h0001;
			end
		end
	end

	// Match flags; a new match beats a software clear in the same cycle.
	logic lowerSet, upperSet, flagWr;
	assign lowerSet = !wide && lowerTick && lowerMatch;
	assign upperSet = wide ? (lowerTick && wideMatch)
		: (upperTick && upperMatch);
	assign flagWr = wrAcc && wb_adr_i == `TPIC_OFS_FLAG && wb_sel_i[0];
	always_ff @(posedge clock) begin
		if (!resetn) begin
			lowerFlag_reg <= 1'b0;
			upperFlag_reg <= 1'b0;
		end else begin
			lowerFlag_reg <= lowerSet || (lowerFlag_reg
				&& !(flagWr && wb_dat_i[0]));
			upperFlag_reg <= upperSet || (upperFlag_reg
				&& !(flagWr && wb_dat_i[1]));
		end
	end
	assign lowerMatchFlag = lowerFlag_reg;
	assign upperMatchFlag = upperFlag_reg;

	// Timer control and period registers.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			lowerCtl_reg <= `TPIC_RST_CTL;
			upperCtl_reg <= `TPIC_RST_CTL;
			lowerPeriod_reg <= `TPIC_RST_PER;
			upperPeriod_reg <= `TPIC_RST_PER;
		end else if (wrAcc) begin
			case (wb_adr_i)
				`TPIC_OFS_LCTL: lowerCtl_reg <= merge16(lowerCtl_reg,
					`TPIC_LCTL_MASK);
				`TPIC_OFS_UCTL: upperCtl_reg <= merge16(upperCtl_reg,
					`TPIC_UCTL_MASK);
				`TPIC_OFS_LPER: lowerPeriod_reg <= merge16(lowerPeriod_reg,
					16'hFFFF);
				`TPIC_OFS_UPER: upperPeriod_reg <= merge16(upperPeriod_reg,
					16'hFFFF);
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Capture channels
	// ------------------------------------------------------------------
	logic [NCH-1:0] bufRead, ctlWrite, wakeHit;
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gCh
			localparam logic [7:0] CBASE = 8'(`TPIC_OFS_CH0
				+ g * `TPIC_CH_STRIDE);
			tpic_cmode_t mode;
			logic halted, rise, fall, event_, full, push, pop;
			logic [1:0] need;
			assign mode = tpic_cmode_t'(capCtl_reg[g][2:0]);
			assign halted = capCtl_reg[g][`TPIC_B_SIDL] && cpuIdle;
			assign rise = captureInputPin[g] && !pinPrev_reg[g];
			assign fall = !captureInputPin[g] && pinPrev_reg[g];
			assign ctlWrite[g] = wrAcc && wb_adr_i == CBASE;
			assign bufRead[g] = rdAcc
				&& wb_adr_i == CBASE + `TPIC_CH_BUF;
			assign full = fill_reg[g] == 3'(`TPIC_FIFO_DEPTH);
			assign pop = bufRead[g] && fill_reg[g] != 3'h0;
			// Mode 111 only wakes; it never stores a value.
			assign wakeHit[g] = mode == TPIC_CM_WAKE && rise
				&& (cpuSleep || cpuIdle);
			always_comb begin
				event_ = 1'b0;
				case (mode)
					TPIC_CM_BOTH: event_ = rise || fall;
					TPIC_CM_FALL: event_ = fall;
					TPIC_CM_RISE: event_ = rise;
					TPIC_CM_RISE4: event_ = rise && preCnt_reg[g][1:0] == 2'h3;
					TPIC_CM_RISE16: event_ = rise && preCnt_reg[g] == 4'hF;
					default: event_ = 1'b0;
				endcase
				event_ = event_ && !halted;
			end
			// A capture into a full store is dropped and flagged, unless a buffer read frees a word in the same cycle.
			assign push = event_ && (!full || pop);
			assign need = capCtl_reg[g][`TPIC_B_IRQHI:`TPIC_B_IRQLO];
			// Edge history and rising-edge prescale count.
			always_ff @(posedge clock) begin
				if (!resetn) begin
					pinPrev_reg[g] <= 1'b0;
					preCnt_reg[g] <= 4'h0;
				end else begin
					pinPrev_reg[g] <= captureInputPin[g];
					if (ctlWrite[g] || mode < TPIC_CM_RISE4) begin
						preCnt_reg[g] <= 4'h0;
					end else if (rise && !halted) begin
						preCnt_reg[g] <= preCnt_reg[g] + 4'h1;
					end
				end
			end

			// Four-word store; the captured word follows base select.
			always_ff @(posedge clock) begin
				if (!resetn) begin
					rdPtr_reg[g] <= 2'h0;
					wrPtr_reg[g] <= 2'h0;
					fill_reg[g] <= 3'h0;
				end else begin
					if (push) begin
						fifo_reg[g][wrPtr_reg[g]] <= capCtl_reg[g][`TPIC_B_BASE]
							? lowerCount_reg : upperCount_reg;
						wrPtr_reg[g] <= wrPtr_reg[g] + 2'h1;
					end
					rdPtr_reg[g] <= rdPtr_reg[g] + 2'(pop);
					fill_reg[g] <= fill_reg[g] + 3'(push) - 3'(pop);
				end
			end

			// Overflow: set wins; cleared once the store reads empty.
			always_ff @(posedge clock) begin
				if (!resetn) begin
					ovf_reg[g] <= 1'b0;
				end else if (event_ && full && !pop) begin
					ovf_reg[g] <= 1'b1;
				end else if (pop && fill_reg[g] == 3'h1) begin
					ovf_reg[g] <= 1'b0;
				end
			end

			// Interrupt pulse after the chosen number of captures.
			always_ff @(posedge clock) begin
				if (!resetn) begin
					irqCnt_reg[g] <= 2'h0;
					capIrq_reg[g] <= 1'b0;
				end else begin
					capIrq_reg[g] <= wakeHit[g];
					if (ctlWrite[g]) begin
						irqCnt_reg[g] <= 2'h0;
					end else if (push) begin
						if (mode == TPIC_CM_BOTH || irqCnt_reg[g] == need) begin
							capIrq_reg[g] <= 1'b1;
							irqCnt_reg[g] <= 2'h0;
						end else begin
							irqCnt_reg[g] <= irqCnt_reg[g] + 2'h1;
						end
					end
				end
			end

			// Channel control register.
			always_ff @(posedge clock) begin
				if (!resetn) begin
					capCtl_reg[g] <= `TPIC_RST_CTL;
				end else if (ctlWrite[g]) begin
					capCtl_reg[g] <= merge16(capCtl_reg[g], `TPIC_CCTL_MASK);
				end
			end
		end
	endgenerate
	assign captureIrq = capIrq_reg;

	// Wake request is a one-cycle pulse on a wake-mode rising edge during sleep or idle.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			wakeReq_reg <= 1'b0;
		end else begin
			wakeReq_reg <= |wakeHit;
		end
	end
	assign wakeRequest = wakeReq_reg;

	// ------------------------------------------------------------------
	// Read mux and acknowledge
	// ------------------------------------------------------------------
	logic [15:0] rmux;
	always_comb begin
		rmux = 16'h0000;
		case (wb_adr_i)
			`TPIC_OFS_LCTL: rmux = lowerCtl_reg;
			`TPIC_OFS_UCTL: rmux = upperCtl_reg;
			`TPIC_OFS_LCNT: rmux = lowerCount_reg;
			`TPIC_OFS_UCNT: rmux = upperCount_reg;
			`TPIC_OFS_LPER: rmux = lowerPeriod_reg;
			`TPIC_OFS_UPER: rmux = upperPeriod_reg;
			`TPIC_OFS_FLAG: rmux = {14'h0000, upperFlag_reg, lowerFlag_reg};
			`TPIC_OFS_SYS: rmux = {15'h0000, cpuIdle};
			default: rmux = 16'h0000;
		endcase
		for (int i = 0; i < NCH; i++) begin
			if (wb_adr_i == 8'(`TPIC_OFS_CH0 + i * `TPIC_CH_STRIDE)) begin
				rmux = capCtl_reg[i];
				rmux[`TPIC_B_OVF] = ovf_reg[i];
				rmux[`TPIC_B_BNE] = fill_reg[i] != 3'h0;
			end
			if (bufRead[i]) begin
				rmux = fifo_reg[i][rdPtr_reg[i]];
			end
		end
	end

	// One answer per request, registered a cycle later; no request is taken in the ack cycle.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			busState_reg <= TPIC_BS_IDLE;
			rdata_reg <= 32'h0000_0000;
		end else begin
			busState_reg <= busReq ? TPIC_BS_ACK : TPIC_BS_IDLE;
			if (busReq) begin
				rdata_reg <= {16'h0000, rmux};
			end
		end
	end
	assign wb_ack_o = busState_reg == TPIC_BS_ACK;
	assign wb_dat_o = rdata_reg;
endmodule // tpic_timer_capture

// ### hw/tpic_map.svh
`ifndef TPIC_MAP_SVH
`define TPIC_MAP_SVH
// ----------------------------------------------------------------------
// Register word offsets (byte addresses on the bus)
// ----------------------------------------------------------------------
`define TPIC_OFS_LCTL 8'h00
`define TPIC_OFS_UCTL 8'h04
`define TPIC_OFS_LCNT 8'h08
`define TPIC_OFS_UCNT 8'h0C
`define TPIC_OFS_LPER 8'h10
`define TPIC_OFS_UPER 8'h14
`define TPIC_OFS_FLAG 8'h18
`define TPIC_OFS_SYS 8'h1C
`define TPIC_OFS_CH0 8'h20
// ----------------------------------------------------------------------
// Per-channel layout: control at base, buffer at base plus four
// ----------------------------------------------------------------------
`define TPIC_CH_STRIDE 8'h08
`define TPIC_CH_BUF 8'h04
// ----------------------------------------------------------------------
// Timer control fields
// ----------------------------------------------------------------------
`define TPIC_B_RUN 15
`define TPIC_B_SIDL 13
`define TPIC_B_GATE 6
`define TPIC_B_DIVHI 5
`define TPIC_B_DIVLO 4
`define TPIC_B_WIDE 3
`define TPIC_B_CSRC 1
`define TPIC_LCTL_MASK 16'hA07A
`define TPIC_UCTL_MASK 16'hA072
// ----------------------------------------------------------------------
// Capture control fields
// ----------------------------------------------------------------------
`define TPIC_B_BASE 7
`define TPIC_B_IRQHI 6
`define TPIC_B_IRQLO 5
`define TPIC_B_OVF 4
`define TPIC_B_BNE 3
`define TPIC_CCTL_MASK 16'h20E7
// ----------------------------------------------------------------------
// Reset values and prescale counts
// ----------------------------------------------------------------------
`define TPIC_RST_CTL 16'h0000
`define TPIC_RST_PER 16'hFFFF
`define TPIC_DIV8 8'h07
`define TPIC_DIV64 8'h3F
`define TPIC_DIV256 8'hFF
`define TPIC_FIFO_DEPTH 4
`endif

// ### hw/tpic_pkg.sv
package tpic_pkg;
	// Capture trigger modes.
	typedef enum logic [2:0] {
		TPIC_CM_OFF = 3'h0,
		TPIC_CM_BOTH = 3'h1,
		TPIC_CM_FALL = 3'h2,
		TPIC_CM_RISE = 3'h3,
		TPIC_CM_RISE4 = 3'h4,
		TPIC_CM_RISE16 = 3'h5,
		TPIC_CM_UNUSED = 3'h6,
		TPIC_CM_WAKE = 3'h7
	} tpic_cmode_t;
	// Bus answer state.
	typedef enum logic [0:0] {
		TPIC_BS_IDLE = 1'b0,
		TPIC_BS_ACK = 1'b1
	} tpic_bstate_t;
endpackage

// ### sim/tpic_timer_capture_chk.sv
`timescale 1ns/1ps
`include "tpic_map.svh"
// ------------------------------------------------------------
// Port checker for the timer pair and capture block
// ------------------------------------------------------------
module tpic_timer_capture_chk #(
	parameter int NCH = 8
) (
	// System.
	input wire logic clock,
	input wire logic resetn,
	// Bus.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Power state and events.
	input wire logic cpuIdle,
	input wire logic cpuSleep,
	input wire logic lowerMatchFlag,
	input wire logic upperMatchFlag,
	input wire logic [NCH-1:0] captureIrq,
	input wire logic wakeRequest
);
	logic flagWr;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	// Only a write to the flag word may lower a sticky flag.
	assign flagWr = wb_cyc_i && wb_we_i && wb_adr_i == `TPIC_OFS_FLAG;
	// A request counts only while no answer is being given.
	sequence reqTaken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ackOnce;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	ack_latency_a: assert property (reqTaken |=> ackOnce)
		else $error("ack not a single cycle after request");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	dat_hold_a: assert property (!wb_cyc_i |=> $stable(wb_dat_o))
		else $error("read data moved without access");
	low_sticky_a: assert property (lowerMatchFlag && !flagWr |=> lowerMatchFlag)
		else $error("lower flag dropped by itself");
	up_sticky_a: assert property (upperMatchFlag && !flagWr |=> upperMatchFlag)
		else $error("upper flag dropped by itself");
	wake_pulse_a: assert property (wakeRequest |=> !wakeRequest)
		else $error("wake longer than one cycle");
	wake_state_a: assert property (wakeRequest |-> $past(cpuIdle || cpuSleep))
		else $error("wake outside sleep or idle");
	reset_clear_a: assert property ($rose(resetn) |-> !wb_ack_o && !lowerMatchFlag
		&& !upperMatchFlag && captureIrq == '0 && !wakeRequest)
		else $error("outputs not clear after reset");
endmodule // tpic_timer_capture_chk

bind tpic_timer_capture tpic_timer_capture_chk #(.NCH(NCH)) u_chk (
	.clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpuIdle(cpuIdle),
	.cpuSleep(cpuSleep), .lowerMatchFlag(lowerMatchFlag),
	.upperMatchFlag(upperMatchFlag), .captureIrq(captureIrq),
	.wakeRequest(wakeRequest)
);

// ### sim/tpic_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Pin source: capture inputs 0 to 7, lower count pin at 8
// ------------------------------------------------------------
module tpic_pin_model (
	// Clock.
	input wire logic clock,
	// Pins driven low when quiet.
	output logic [8:0] pin
);
	initial pin = 9'h000;
	// Three clocks high and three low, so a one-clock sampler sees
	// every edge; faster pulses would need a synchroniser model.
	task pulses(input int ch, input int n);
		repeat (n) begin
			repeat (3) @(posedge clock);
			pin[ch] <= 1'b1;
			repeat (3) @(posedge clock);
			pin[ch] <= 1'b0;
		end
	endtask
endmodule // tpic_pin_model

// ### sim/tb.sv
`timescale 1ns/1ps
`include "tpic_map.svh"
module tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [7:0] LC = `TPIC_OFS_LCTL, UC = `TPIC_OFS_UCTL;
	localparam logic [7:0] LN = `TPIC_OFS_LCNT, UN = `TPIC_OFS_UCNT;
	localparam logic [7:0] LP = `TPIC_OFS_LPER, UP = `TPIC_OFS_UPER;
	localparam logic [7:0] FL = `TPIC_OFS_FLAG, C0 = `TPIC_OFS_CH0;
	logic clock = 0, resetn = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
	logic cpuIdle = 0, cpuSleep = 0, lowerGate = 1, wbAck;
	logic lowFlag, upFlag, wake;
	logic [7:0] wbAdr = 8'h00, capIrq;
	logic [8:0] pin;
	logic [31:0] wbDatI = 32'h0, wbDatO, expQ[$];
	int n_mismatch = 0, checks = 0, irqCnt = 0, wakeCnt = 0, cyc = 0;
	int k, p, ch;
	int dv[4] = '{1, 8, 64, 256};
	int np[7] = '{4, 2, 4, 4, 16, 16, 4};
	int mc[7] = '{0, 4, 4, 4, 4, 1, 0};

	tpic_timer_capture #(.NCH(8)) i_tpic_timer_capture (
		.clock(clock), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h3), .wb_dat_i(wbDatI),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .cpuIdle(cpuIdle),
		.cpuSleep(cpuSleep), .lowerGate(lowerGate), .upperGate(1'b0),
		.lowerExtCountPin(pin[8]), .upperExtCountPin(1'b0),
		.captureInputPin(pin[7:0]), .lowerMatchFlag(lowFlag),
		.upperMatchFlag(upFlag), .captureIrq(capIrq), .wakeRequest(wake)
	);
	tpic_pin_model u_pins (.clock(clock), .pin(pin));

	// Clock, cycle count and event tallies.
	initial forever #25 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		irqCnt <= irqCnt + $countones(capIrq);
		wakeCnt <= wakeCnt + (wake === 1'b1);
	end
	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task check(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	// Read data is judged at the ack edge against the oldest note.
	always @(posedge clock)
		if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0)
			check("read", expQ.pop_front(), wbDatO);
	task wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatI <= d;
		do begin
			@(posedge clock);
			t++;
		end while (wbAck !== 1'b1 && t < 50);
		if (t >= 50) check("ack", 32'h1, 32'h0);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clock);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		wbx(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		wbx(1'b0, a, 32'h0);
	endtask
	task setT(input logic [31:0] c, input logic [31:0] n, input logic [31:0] r);
		wr(LC, 32'h0);
		wr(LN, n);
		wr(LP, r);
		wr(LC, c);
	endtask
	task waitF(input bit up);
		int t;
		t = 0;
		while ((up ? upFlag : lowFlag) !== 1'b1 && t < 2000) begin
			@(posedge clock);
			t++;
		end
	endtask
	// Span between two flag rises, so start-up latency drops out.
	task period(input bit up, input int e);
		int t0;
		wr(FL, 32'h3);
		waitF(up);
		t0 = cyc;
		wr(FL, 32'h3);
		waitF(up);
		check("period", e, cyc - t0);
	endtask
	task quiet(input bit up);
		wr(FL, 32'h3);
		repeat (100) @(posedge clock);
		check("noflag", 32'h0, {31'h0, up ? upFlag : lowFlag});
	endtask
	task cap(input logic [15:0] c, input int nr, input int nc, input int ni);
		logic [7:0] a;
		logic [31:0] e;
		int i0;
		a = 8'(C0 + 8 * ch);
		e = {16'h0, c};
		e[4] = nc > 4;
		e[3] = nc > 0;
		wr(a, {16'h0, c});
		i0 = irqCnt;
		u_pins.pulses(ch, nr);
		repeat (4) @(posedge clock);
		if (ni >= 0) check("irqs", ni, irqCnt - i0);
		rd(a, e);
		repeat (nc > 4 ? 4 : nc) rd(a + `TPIC_CH_BUF, c[7] ? 32'h1234 : 32'h5678);
		rd(a, {16'h0, c});
		wr(a, 32'h0);
	endtask
	task done(input string s);
		$display("test %s done", s);
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog well beyond the few thousand cycles the tests need.
	initial begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		$display("[ERR] watchdog exp done got hang");
		results();
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h06B9));
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		rd(LC, 32'h0);
		rd(LP, 32'hFFFF);
		rd(UP, 32'hFFFF);
		wr(8'h60, 32'hFFFF);
		rd(8'h60, 32'h0);
		wr(LC, 32'hFFFF);
		rd(LC, 32'hA07A);
		wr(UC, 32'hFFFF);
		rd(UC, 32'hA072);
		wr(C0, 32'hFFFF);
		rd(C0, 32'h20E7);
		wr(C0, 32'h0);
		wr(UC, 32'h0);
		done("registers");
		for (int d = 0; d < 4; d++) begin
			p = d == 0 ? 19 + $urandom % 20 : d == 1 ? 2 + $urandom % 3 : 0;
			setT(32'h8000 | d << 4, 32'h0, p);
			period(1'b0, (p + 1) * dv[d]);
		end
		lowerGate <= 1'b0;
		setT(32'h8040, 32'h0, 32'd19);
		quiet(1'b0);
		lowerGate <= 1'b1;
		period(1'b0, 20);
		cpuIdle <= 1'b1;
		wr(LC, 32'hA000);
		quiet(1'b0);
		wr(LC, 32'h8000);
		period(1'b0, 20);
		cpuIdle <= 1'b0;
		setT(32'h8002, 32'h0, 32'h3);
		quiet(1'b0);
		u_pins.pulses(8, 4);
		repeat (4) @(posedge clock);
		check("extflag", 32'h1, {31'h0, lowFlag});
		wr(UP, 32'h3);
		wr(UC, 32'h8010);
		period(1'b1, 32);
		wr(UN, 32'h0);
		wr(UP, 32'h0);
		wr(UC, 32'h0030);
		setT(32'h8008, 32'h0, 32'd20);
		period(1'b1, 21);
		quiet(1'b0);
		cpuIdle <= 1'b1;
		wr(LC, 32'hA008);
		quiet(1'b1);
		cpuIdle <= 1'b0;
		wr(UP, 32'hFFFF);
		wr(UN, 32'h0);
		setT(32'h8008, 32'hFFFE, 32'hFFFF);
		repeat (8) @(posedge clock);
		wr(LC, 32'h0);
		rd(UN, 32'h1);
		done("timers");
		wr(UC, 32'h0);
		wr(LN, 32'h1234);
		wr(UN, 32'h5678);
		for (int m = 0; m < 7; m++) begin
			ch = $urandom % 8;
			cap(16'(m | ($urandom % 2) << 7), np[m], mc[m], mc[m]);
		end
		ch = 1;
		for (int i = 0; i < 4; i++)
			cap(16'(32'h83 | i << 5), 4, 4, 4 / (i + 1));
		cap(16'h0061, 2, 4, 4);
		cap(16'h0083, 5, 5, -1);
		cpuIdle <= 1'b1;
		cap(16'h2083, 4, 0, 0);
		cpuIdle <= 1'b0;
		ch = 0;
		wr(C0, 32'h7);
		k = wakeCnt;
		u_pins.pulses(0, 2);
		repeat (4) @(posedge clock);
		check("wake", k, wakeCnt);
		cpuSleep <= 1'b1;
		u_pins.pulses(0, 2);
		repeat (4) @(posedge clock);
		check("wake", k + 2, wakeCnt);
		cpuSleep <= 1'b0;
		rd(C0, 32'h7);
		done("capture");
		resetn <= 1'b0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		rd(LP, 32'hFFFF);
		rd(C0, 32'h0);
		rd(UN, 32'h0);
		done("reset");
		results();
	end
endmodule // tb
